// ---- hw/dmrr_framer.sv ----
// Memory read response frame builder for the single-wire debug link
//
// Function
// [RULE_01] Frame order: 55, C1, length, data MSB first, status, remaining, CRC.
// [RULE_02] Status 00 success, 01 access bus busy, 02 wrong address.
// [RULE_03] Fault-free read sends status zero and remaining count zero.
// [RULE_04] After a fault the full data field is still sent, filler bytes.
// [RULE_05] Remaining count holds field bytes still unsent when the fault hit; the code sends that count plus three.
// [RULE_06] Length equals data byte count plus three.
`default_nettype none
module dmrr_framer (
    input  wire logic                  ref_clk,
    input  wire logic                  rst_b,
    input  wire logic                  ce,
    input  wire logic                  reqValid,
    input  wire dmrr_pkg::dmrr_req_s   req,
    output logic                       reqReady,
    output logic                       busReq,
    output logic [31:0]                busAddr,
    input  wire dmrr_pkg::dmrr_busrsp_s busRsp,
    input  wire logic [15:0]           crcValue,
    output logic                       txValid,
    output logic [7:0]                 txByte,
    input  wire logic                  txReady,
    output logic                       frameDone
);
    // ***********************************
    // State
    // ***********************************
    dmrr_pkg::dmrr_state_e stateQ, stateD;
    logic [31:0] addrQ;
    logic [15:0] lenQ;
    logic [15:0] leftQ;
    logic [15:0] remQ;
    logic [7:0]  statusQ;
    logic [7:0]  dataQ;
    logic        faultQ;

    function automatic logic [7:0] hi(input logic [15:0] v);
        return v[15:8];
    endfunction : hi

    function automatic logic [7:0] lo(input logic [15:0] v);
        return v[7:0];
    endfunction : lo

    // ***********************************
    // Decode
    // ***********************************
    wire        start     = reqValid && reqReady;
    wire        rspTaken  = (stateQ == dmrr_pkg::ST_FETCH) && busRsp.valid && ce;
    wire        rspFault  = busRsp.busy || busRsp.err;
    wire [7:0]  rspStatus = busRsp.busy ? dmrr_pkg::STAT_BUSY          // RULE_02
                          : (busRsp.err ? dmrr_pkg::STAT_BUSERR : dmrr_pkg::STAT_OK);
    wire        emitting  = (stateQ != dmrr_pkg::ST_IDLE) && (stateQ != dmrr_pkg::ST_FETCH);
    wire        inReady;
    logic [7:0] emitByte;
    wire        emit      = emitting && inReady;
    wire        lastData  = (leftQ == dmrr_pkg::ONE_16);
    wire [15:0] lenField  = lenQ + dmrr_pkg::LEN_EXTRA;                // RULE_06

    assign reqReady  = ce && (stateQ == dmrr_pkg::ST_IDLE);
    assign busReq    = ce && (stateQ == dmrr_pkg::ST_FETCH);
    assign busAddr   = addrQ;
    assign frameDone = emit && (stateQ == dmrr_pkg::ST_CRCL);

    // Byte offered in each emitting state, in frame order
    always_comb begin
        unique case (stateQ)                                              // RULE_01
            dmrr_pkg::ST_SYNC: emitByte = dmrr_pkg::SYNC_BYTE;
            dmrr_pkg::ST_CODE: emitByte = dmrr_pkg::RESP_CODE;
            dmrr_pkg::ST_LENH: emitByte = hi(lenField);
            dmrr_pkg::ST_LENL: emitByte = lo(lenField);
            dmrr_pkg::ST_DATA: emitByte = faultQ ? dmrr_pkg::FILL_BYTE : dataQ; // RULE_04
            dmrr_pkg::ST_STAT: emitByte = statusQ;
            dmrr_pkg::ST_REMH: emitByte = hi(remQ);
            dmrr_pkg::ST_REML: emitByte = lo(remQ);
            dmrr_pkg::ST_CRCH: emitByte = hi(crcValue);
            dmrr_pkg::ST_CRCL: emitByte = lo(crcValue);
            default:           emitByte = dmrr_pkg::FILL_BYTE;
        endcase
    end

    // ***********************************
    // Sequencer
    // ***********************************
    always_comb begin
        stateD = stateQ;
        unique case (stateQ)
            dmrr_pkg::ST_IDLE:  if (start) stateD = dmrr_pkg::ST_SYNC;
            dmrr_pkg::ST_SYNC:  if (emit) stateD = dmrr_pkg::ST_CODE;
            dmrr_pkg::ST_CODE:  if (emit) stateD = dmrr_pkg::ST_LENH;
            dmrr_pkg::ST_LENH:  if (emit) stateD = dmrr_pkg::ST_LENL;
            dmrr_pkg::ST_LENL: begin
                if (emit) begin
                    stateD = (lenQ == 16'h0000) ? dmrr_pkg::ST_STAT : dmrr_pkg::ST_FETCH;
                end
            end
            dmrr_pkg::ST_FETCH: if (rspTaken) stateD = dmrr_pkg::ST_DATA;
            dmrr_pkg::ST_DATA: begin
                if (emit) begin
                    if (lastData) begin
                        stateD = dmrr_pkg::ST_STAT;
                    end else if (faultQ) begin
                        stateD = dmrr_pkg::ST_DATA;
                    end else begin
                        stateD = dmrr_pkg::ST_FETCH;
                    end
                end
            end
            dmrr_pkg::ST_STAT:  if (emit) stateD = dmrr_pkg::ST_REMH;
            dmrr_pkg::ST_REMH:  if (emit) stateD = dmrr_pkg::ST_REML;
            dmrr_pkg::ST_REML:  if (emit) stateD = dmrr_pkg::ST_CRCH;
            dmrr_pkg::ST_CRCH:  if (emit) stateD = dmrr_pkg::ST_CRCL;
            dmrr_pkg::ST_CRCL:  if (emit) stateD = dmrr_pkg::ST_IDLE;
            default:            stateD = dmrr_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            stateQ <= dmrr_pkg::ST_IDLE;
        end else if (ce) begin
            stateQ <= stateD;
        end
    end

    // ***********************************
    // Frame data path
    // ***********************************
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            addrQ   <= 32'h0000_0000;
            lenQ    <= 16'h0000;
            leftQ   <= 16'h0000;
            remQ    <= 16'h0000;
            statusQ <= dmrr_pkg::STAT_OK;
            dataQ   <= 8'h00;
            faultQ  <= 1'b0;
        end else if (ce) begin
            if (start) begin
                addrQ   <= req.addr;
                lenQ    <= req.count;
                leftQ   <= req.count;
                remQ    <= 16'h0000;                                     // RULE_03
                statusQ <= dmrr_pkg::STAT_OK;                            // RULE_03
                faultQ  <= 1'b0;
            end
            // A fault stops further reads; the rest of the field is filler
            if (rspTaken) begin
                dataQ <= busRsp.data;
                addrQ <= addrQ + dmrr_pkg::ADDR_STEP;
                if (rspFault) begin
                    faultQ  <= 1'b1;                                     // RULE_04
                    statusQ <= rspStatus;                                // RULE_02
                    remQ    <= leftQ + dmrr_pkg::LEN_EXTRA;              // RULE_05
                end
            end
            if (emit && stateQ == dmrr_pkg::ST_DATA) begin
                leftQ <= leftQ - dmrr_pkg::ONE_16;
            end
        end
    end

    dmrr_out_reg u_out (
        .ref_clk  (ref_clk),
        .rst_b    (rst_b),
        .ce       (ce),
        .inValid  (emitting),
        .inByte   (emitByte),
        .inReady  (inReady),
        .outValid (txValid),
        .outByte  (txByte),
        .outReady (txReady)
    );

    // ***********************************
    // Checks
    // ***********************************
    chk_sync_then_code: assert property (@(posedge ref_clk) disable iff (!rst_b)   // RULE_01
        emit && stateQ == dmrr_pkg::ST_SYNC
        |=> txByte == dmrr_pkg::SYNC_BYTE && txValid == ce && stateQ == dmrr_pkg::ST_CODE)
        else $error("Sync byte not sent first");
    chk_code_value: assert property (@(posedge ref_clk) disable iff (!rst_b)       // RULE_01
        emit && stateQ == dmrr_pkg::ST_CODE |-> emitByte == dmrr_pkg::RESP_CODE)
        else $error("Wrong response code");
    chk_status_code: assert property (@(posedge ref_clk) disable iff (!rst_b)      // RULE_02
        rspTaken && busRsp.err && !busRsp.busy |=> statusQ == dmrr_pkg::STAT_BUSERR)
        else $error("Bus error not reported as 02");
    chk_busy_status: assert property (@(posedge ref_clk) disable iff (!rst_b)      // RULE_02
        rspTaken && busRsp.busy |=> statusQ == dmrr_pkg::STAT_BUSY)
        else $error("Busy access bus not reported as 01");
    chk_clean_trailer: assert property (@(posedge ref_clk) disable iff (!rst_b)    // RULE_03
        emit && stateQ == dmrr_pkg::ST_STAT && !faultQ
        |-> emitByte == dmrr_pkg::STAT_OK && remQ == 16'h0000)
        else $error("Clean read without zero status and count");
    chk_fault_fill: assert property (@(posedge ref_clk) disable iff (!rst_b)       // RULE_04
        emit && stateQ == dmrr_pkg::ST_DATA && faultQ && !lastData
        |=> stateQ == dmrr_pkg::ST_DATA && leftQ == $past(leftQ) - dmrr_pkg::ONE_16)
        else $error("Data field cut short after fault");
    chk_no_read_fault: assert property (@(posedge ref_clk) disable iff (!rst_b)    // RULE_04
        faultQ |-> !busReq)
        else $error("Bus read issued after a fault");
    chk_fault_remain: assert property (@(posedge ref_clk) disable iff (!rst_b)     // RULE_05
        rspTaken && rspFault && !faultQ |=> remQ == $past(leftQ) + dmrr_pkg::LEN_EXTRA)
        else $error("Remaining count wrong after fault");
    chk_length_field: assert property (@(posedge ref_clk) disable iff (!rst_b)     // RULE_06
        emit && stateQ == dmrr_pkg::ST_LENL |-> emitByte == lo(lenQ + dmrr_pkg::LEN_EXTRA))
        else $error("Length field not data plus three");
    chk_length_high: assert property (@(posedge ref_clk) disable iff (!rst_b)      // RULE_06
        emit && stateQ == dmrr_pkg::ST_LENH |-> emitByte == hi(lenQ + dmrr_pkg::LEN_EXTRA))
        else $error("Length high byte wrong");
    chk_no_bus_idle: assert property (@(posedge ref_clk) disable iff (!rst_b)
        stateQ == dmrr_pkg::ST_IDLE |-> !busReq)
        else $error("Bus request outside a frame");

    cov_clean_frame: cover property (@(posedge ref_clk) disable iff (!rst_b)
        frameDone && !faultQ);
    cov_busy_frame: cover property (@(posedge ref_clk) disable iff (!rst_b)
        frameDone && statusQ == dmrr_pkg::STAT_BUSY);
    cov_err_frame: cover property (@(posedge ref_clk) disable iff (!rst_b)
        frameDone && statusQ == dmrr_pkg::STAT_BUSERR);
    cov_empty_frame: cover property (@(posedge ref_clk) disable iff (!rst_b)
        frameDone && lenQ == 16'h0000);
    cov_fill_byte: cover property (@(posedge ref_clk) disable iff (!rst_b)
        emit && stateQ == dmrr_pkg::ST_DATA && faultQ);
endmodule : dmrr_framer
`default_nettype wire

// ---- hw/dmrr_pkg.sv ----
// Constants and carrier types for the memory read response framer
`default_nettype none
package dmrr_pkg;
    localparam logic [7:0]  SYNC_BYTE   = 8'h55;
    localparam logic [7:0]  RESP_CODE   = 8'hc1;
    localparam logic [7:0]  STAT_OK     = 8'h00;
    localparam logic [7:0]  STAT_BUSY   = 8'h01;
    localparam logic [7:0]  STAT_BUSERR = 8'h02;
    localparam logic [7:0]  FILL_BYTE   = 8'h00;
    localparam logic [15:0] LEN_EXTRA   = 16'h0003;
    localparam logic [15:0] ONE_16      = 16'h0001;
    localparam logic [31:0] ADDR_STEP   = 32'h0000_0001;

    typedef enum logic [3:0] {
        ST_IDLE, ST_SYNC, ST_CODE, ST_LENH, ST_LENL, ST_FETCH, ST_DATA,
        ST_STAT, ST_REMH, ST_REML, ST_CRCH, ST_CRCL
    } dmrr_state_e;

    typedef struct packed {
        logic [31:0] addr;
        logic [15:0] count;
    } dmrr_req_s;

    typedef struct packed {
        logic       valid;
        logic       busy;
        logic       err;
        logic [7:0] data;
    } dmrr_busrsp_s;
endpackage : dmrr_pkg
`default_nettype wire

// ---- hw/dmrr_out_reg.sv ----
// One-byte output holding register with valid/ready on both sides
`default_nettype none
module dmrr_out_reg (
    input  wire logic       ref_clk,
    input  wire logic       rst_b,
    input  wire logic       ce,
    input  wire logic       inValid,
    input  wire logic [7:0] inByte,
    output logic            inReady,
    output logic            outValid,
    output logic [7:0]      outByte,
    input  wire logic       outReady
);
    logic       validQ;
    logic [7:0] byteQ;
    wire        load = inValid && inReady;

    assign inReady  = ce && (!validQ || outReady);
    // Offer is withdrawn while frozen so the consumer cannot take a byte twice
    assign outValid = ce && validQ;
    assign outByte  = byteQ;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            validQ <= 1'b0;
            byteQ  <= 8'h00;
        end else if (ce) begin
            if (load) begin
                validQ <= 1'b1;
                byteQ  <= inByte;
            end else if (outReady) begin
                validQ <= 1'b0;
            end
        end
    end

    chk_hold_stable: assert property (@(posedge ref_clk) disable iff (!rst_b)
        validQ && !outReady && ce |=> validQ && $stable(byteQ))
        else $error("Output byte changed while stalled");
endmodule : dmrr_out_reg
`default_nettype wire

// ---- sim/dmrr_host_model.sv ----
// Debugger-side consumer of response bytes, with optional stalling
`default_nettype none
module dmrr_host_model (
    input  wire logic       ref_clk,
    input  wire logic       stallOn,
    input  wire logic       txValid,
    input  wire logic [7:0] txByte,
    output logic            txReady,
    output logic            rxStrobe,
    output logic [7:0]      rxByte
);
    timeunit 1ns;
    timeprecision 1ps;
    // Stalls are random so bytes must hold across several edges
    always @(negedge ref_clk) txReady <= !(stallOn && ($urandom % 2 == 0));
    assign rxStrobe = txValid && txReady;
    assign rxByte   = txByte;
endmodule : dmrr_host_model
`default_nettype wire

// ---- sim/dmrr_framer_test.sv ----
// Self-checking bench for the memory read response framer
`default_nettype none
module dmrr_framer_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic refClk, rstB, ce, reqValid, reqReady, busReq, txValid, txReady, frameDone;
    logic rxStrobe, stallOn, ceDrop, tookIt;
    logic [7:0] txByte, rxByte, e;
    logic [31:0] busAddr, base;
    logic [15:0] crcValue;
    dmrr_pkg::dmrr_req_s    req;
    dmrr_pkg::dmrr_busrsp_s busRsp;
    logic [7:0] q[$];
    int error_cnt, compares, idx, fIdx, fKind, n;
    dmrr_framer i_dmrr_framer (.ref_clk(refClk), .rst_b(rstB), .ce(ce), .reqValid(reqValid),
        .req(req), .reqReady(reqReady), .busReq(busReq), .busAddr(busAddr), .busRsp(busRsp),
        .crcValue(crcValue), .txValid(txValid), .txByte(txByte), .txReady(txReady),
        .frameDone(frameDone));
    dmrr_host_model i_dmrr_host_model (.ref_clk(refClk), .stallOn(stallOn), .txValid(txValid),
        .txByte(txByte), .txReady(txReady), .rxStrobe(rxStrobe), .rxByte(rxByte));
    // ************************************
    // Clock, checks and reporting
    // ************************************
    initial begin
        refClk = 1'b0;
        forever #12.5 refClk = ~refClk;
    end
    function automatic logic [7:0] dval(input logic [31:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h5a;
    endfunction : dval
    task automatic note_err(input string msg);
        error_cnt++;
        $display("MISMATCH at %0t: %s", $time, msg);
    endtask : note_err
    task automatic finish_test;
        $display("Counts: %0d compares, %0d mismatches", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : finish_test
    always @(posedge refClk) begin
        if (rxStrobe === 1'b1) begin
            compares++;
            if (q.size() == 0) note_err("unexpected byte");
            else begin
                e = q.pop_front();
                if (rxByte !== e) note_err("frame byte differs");
            end
        end
    end
    // ************************************
    // Access bus responder
    // ************************************
    always @(posedge refClk) begin
        if (busReq === 1'b1 && busRsp.valid) begin
            compares++;
            if (busAddr !== base + 32'(idx) || (fKind != 0 && idx > fIdx)) note_err("bad read");
            idx++;
            tookIt = 1'b1;
        end
    end
    always @(negedge refClk) begin
        if (!busRsp.valid || tookIt) begin
            if (busReq === 1'b1 && $urandom % 3 != 0)
                busRsp <= {1'b1, idx == fIdx && fKind == 1, idx == fIdx && fKind == 2, dval(busAddr)};
            else busRsp <= {3'h0, 8'($urandom)};
        end
        ce <= !(ceDrop && $urandom % 4 == 0);
        tookIt = 1'b0;
    end
    // ************************************
    // Frame runner
    // ************************************
    task automatic run_frame(input int cnt, input int fi, input int fk);
        logic [15:0] len, rem;
        len = 16'(cnt) + dmrr_pkg::LEN_EXTRA;
        rem = (fk != 0) ? 16'(cnt - fi + 3) : 16'h0000;
        @(negedge refClk);
        base = $urandom;
        crcValue = 16'($urandom);
        idx = 0;
        fIdx = fi;
        fKind = fk;
        q.push_back(dmrr_pkg::SYNC_BYTE);
        q.push_back(dmrr_pkg::RESP_CODE);
        q.push_back(len[15:8]);
        q.push_back(len[7:0]);
        for (int i = 0; i < cnt; i++)
            q.push_back((fk != 0 && i >= fi) ? dmrr_pkg::FILL_BYTE : dval(base + 32'(i)));
        q.push_back(fk == 0 ? dmrr_pkg::STAT_OK : fk == 1 ? dmrr_pkg::STAT_BUSY
                    : dmrr_pkg::STAT_BUSERR);
        q.push_back(rem[15:8]);
        q.push_back(rem[7:0]);
        q.push_back(crcValue[15:8]);
        q.push_back(crcValue[7:0]);
        reqValid = 1'b1;
        req = {base, 16'(cnt)};
        n = 0;
        do begin
            @(posedge refClk);
            n++;
        end while (reqReady !== 1'b1 && n < 50);
        compares++;
        if (reqReady !== 1'b1) note_err("request not taken");
        @(negedge refClk);
        reqValid = 1'b0;
        req = {32'($urandom), 16'($urandom)};
        n = 0;
        do begin
            @(posedge refClk);
            n++;
        end while (frameDone !== 1'b1 && n < 2000);
        compares++;
        if (frameDone !== 1'b1) note_err("frame done pulse missing");
        n = 0;
        while (q.size() != 0 && n < 100) begin
            @(posedge refClk);
            n++;
        end
        compares++;
        if (q.size() != 0 || n >= 100) note_err("frame incomplete");
        q.delete();
        $display("Test done: count %0d fault %0d at %0d", cnt, fk, fi);
    endtask : run_frame
    initial begin
        rstB = 1'b0;
        ce = 1'b1;
        reqValid = 1'b0;
        req = '0;
        busRsp = '0;
        crcValue = 16'h0000;
        stallOn = 1'b0;
        ceDrop = 1'b0;
        tookIt = 1'b0;
        fKind = 0;
        fIdx = 0;
        idx = 0;
        base = '0;
        void'($urandom(37));
        repeat (2) @(negedge refClk);
        rstB = 1'b1;
        run_frame(0, 0, 0);
        run_frame(4, 0, 0);
        run_frame(4, 2, 2);
        run_frame(4, 0, 1);
        stallOn = 1'b1;
        run_frame(3, 2, 2);
        run_frame(1, 0, 1);
        ceDrop = 1'b1;
        for (int t = 0; t < 6; t++) begin
            n = 1 + $urandom % 12;
            run_frame(n, $urandom % n, $urandom % 3);
        end
        finish_test();
    end
    initial begin
        #(25 * 40000);
        note_err("watchdog expired");
        finish_test();
    end
endmodule : dmrr_framer_test
`default_nettype wire
